// ==== dv/glar_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// =========================================
// Host side of the command port; released lines show inverted values.
module glar_host_model
(
   input wire logic clock,
   output logic cmdValid,
   output logic cmdWrite,
   output logic [7:0] cmdCode,
   output logic [15:0] cmdWdata
);
   initial
   begin
      cmdValid = 1'b0;
      cmdWrite = 1'b0;
      cmdCode = 8'h00;
      cmdWdata = 16'h0000;
   end

   task automatic issue(input logic w, input logic [7:0] c, input logic [15:0] d);
      @(posedge clock);
      cmdValid <= 1'b1;
      cmdWrite <= w;
      cmdCode <= c;
      cmdWdata <= d;
   endtask : issue

   task automatic idle();
      @(posedge clock);
      cmdValid <= 1'b0;
      cmdWrite <= ~cmdWrite;
      cmdCode <= ~cmdCode;
      cmdWdata <= ~cmdWdata;
   endtask : idle
endmodule : glar_host_model
`default_nettype wire

// ==== dv/glar_registers_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// =========================================
// Command port and alarm properties.
module glar_registers_properties
   import glar_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic cmdValid,
   input wire logic cmdWrite,
   input wire logic [7:0] cmdCode,
   input wire logic [15:0] cmdWdata,
   input wire logic [15:0] cmdRdata,
   input wire logic cmdRvalid,
   input wire logic cmdError,
   input wire logic nvmLoad,
   input wire logic [15:0] nvmHighVolt,
   input wire logic measValid,
   input wire logic [4:0] alarmFlags
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   a_read_answers: assert property (cmdValid && !cmdWrite && cmdCode == CMD_FLOOR_VOLT
      |=> cmdRvalid && !cmdError) else $error("read got no answer");
   a_write_silent: assert property (cmdValid && cmdWrite && cmdCode == CMD_HIGH_VOLT_THR
      |=> !cmdRvalid && !cmdError) else $error("write answered");
   a_unknown_refused: assert property (cmdValid && cmdCode == 8'h00
      |=> cmdError && !cmdRvalid) else $error("unknown code not refused");
   a_ro_write_refused: assert property (cmdValid && cmdWrite && cmdCode == CMD_CYCLE_COUNT
      |=> cmdError) else $error("read-only write not refused");
   a_answer_cause: assert property (cmdRvalid
      |-> $past(cmdValid) && !$past(cmdWrite)) else $error("answer without read");
   a_thr_readback: assert property ((cmdValid && cmdWrite && cmdCode == CMD_LOW_TEMP_THR
      && !nvmLoad) ##1 (cmdValid && !cmdWrite && cmdCode == CMD_LOW_TEMP_THR && !nvmLoad)
      |=> cmdRdata == $past(cmdWdata, 2)) else $error("threshold readback wrong");
   a_nvm_visible: assert property (nvmLoad ##1 (cmdValid && !cmdWrite
      && cmdCode == CMD_HIGH_VOLT_THR && !nvmLoad)
      |=> cmdRdata == $past(nvmHighVolt, 2)) else $error("load value not read back");
   a_alarm_sampled: assert property (alarmFlags != 5'h00
      |-> $past(measValid)) else $error("alarm without sample");
endmodule : glar_registers_properties
`default_nettype wire

bind glar_registers glar_registers_properties u_props (.clock(clock), .rstn(rstn),
   .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWdata(cmdWdata),
   .cmdRdata(cmdRdata), .cmdRvalid(cmdRvalid), .cmdError(cmdError), .nvmLoad(nvmLoad),
   .nvmHighVolt(nvmHighVolt), .measValid(measValid), .alarmFlags(alarmFlags));

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import glar_pkg::*;
   logic clock, rstn, nvmLoad, measValid, cycleTick, minuteTick;
   logic [15:0] measVoltage, measTemp, chargeLevel, hv, lv, ht, lt, lc, v, d;
   logic [31:0] tag;
   logic [16:0] e;
   wire logic cmdValid, cmdWrite, cmdRvalid, cmdError;
   wire logic [7:0] cmdCode;
   wire logic [15:0] cmdWdata, cmdRdata;
   wire logic [4:0] alarmFlags;
   int n_errors, comparisons;
   logic [16:0] expQ[$];
   logic [4:0] flagQ[$];
   bit flagDue;
   localparam logic [7:0] RC[13] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h19, 8'h1F, 8'h14, 8'h21,
      8'h20, 8'h13, 8'h17, 8'h24, 8'h25};
   localparam logic [15:0] RV[13] = '{PEAK_VOLT_RESET, FLOOR_VOLT_RESET, PEAK_TEMP_RESET,
      FLOOR_TEMP_RESET, ALARM_STATE_RESET, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000};
   localparam logic [7:0] TC[5] = '{8'h1F, 8'h14, 8'h21, 8'h20, 8'h13};
   localparam logic [15:0] TL[5] = '{VOLT_MIN, VOLT_MIN, TEMP_MIN, TEMP_MIN, 16'h0001};
   localparam logic [15:0] TS[5] = '{16'h09C5, 16'h09C5, 16'h044D, 16'h044D, 16'h0064};

   glar_host_model host (.clock(clock), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
      .cmdCode(cmdCode), .cmdWdata(cmdWdata));
   glar_registers #(.VERSION_CODE(16'h5A01), .CHECKSUM_VALUE(32'h1234ABCD)) dut (
      .clock(clock), .rstn(rstn), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
      .cmdCode(cmdCode), .cmdWdata(cmdWdata), .cmdRdata(cmdRdata), .cmdRvalid(cmdRvalid),
      .cmdError(cmdError), .nvmLoad(nvmLoad), .nvmHighVolt(hv), .nvmLowVolt(lv),
      .nvmHighTemp(ht), .nvmLowTemp(lt), .nvmLowCharge(lc), .nvmOwnerTag(tag),
      .measValid(measValid), .measVoltage(measVoltage), .measTemp(measTemp),
      .relativeChargeLevel(chargeLevel), .batteryStateBits(16'h0000),
      .cycleTick(cycleTick), .minuteTick(minuteTick), .alarmFlags(alarmFlags));

   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic fail(input string m);
      n_errors++;
      $display("MISMATCH at %0t: %s", $time, m);
   endtask : fail

   task automatic chk_read(input logic [15:0] x);
      comparisons++;
      if (cmdRvalid !== 1'b1 || cmdError !== 1'b0 || cmdRdata !== x)
         fail($sformatf("read got %h expected %h", cmdRdata, x));
   endtask : chk_read

   task automatic chk_err();
      comparisons++;
      if (cmdError !== 1'b1 || cmdRvalid !== 1'b0)
         fail("refusal missing");
   endtask : chk_err

   task automatic chk_flags(input logic [4:0] x);
      comparisons++;
      if (alarmFlags !== x)
         fail($sformatf("alarm flags %b expected %b", alarmFlags, x));
   endtask : chk_flags

   always @(negedge clock)
   begin
      if (cmdRvalid === 1'b1 || cmdError === 1'b1)
      begin
         if (expQ.size() == 0)
            fail("answer not expected");
         else
         begin
            e = expQ.pop_front();
            if (e[16])
               chk_err();
            else
               chk_read(e[15:0]);
         end
      end
      if (flagDue)
      begin
         if (flagQ.size() == 0)
            fail("alarm flags not expected");
         else
            chk_flags(flagQ.pop_front());
      end
      flagDue = (measValid === 1'b1);
   end

   task automatic rd(input logic [7:0] c, input logic [15:0] x);
      expQ.push_back({1'b0, x});
      host.issue(1'b0, c, 16'h0000);
   endtask : rd

   task automatic bad(input logic w, input logic [7:0] c);
      expQ.push_back({1'b1, 16'h0000});
      host.issue(w, c, 16'h0000);
   endtask : bad

   task automatic sample(input logic [15:0] sv, input logic [15:0] st, input logic [15:0] sc,
                         input logic [4:0] sf);
      flagQ.push_back(sf);
      @(posedge clock);
      measValid <= 1'b1;
      measVoltage <= sv;
      measTemp <= st;
      chargeLevel <= sc;
      @(posedge clock);
      measValid <= 1'b0;
      repeat (2) @(posedge clock);
   endtask : sample

   task automatic tick(input bit minute, input int n);
      repeat (n)
      begin
         @(posedge clock);
         minuteTick <= minute;
         cycleTick <= !minute;
         @(posedge clock);
         minuteTick <= 1'b0;
         cycleTick <= 1'b0;
      end
   endtask : tick

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test

   initial
   begin
      repeat (50000) @(posedge clock);
      fail("timeout");
      end_of_test();
   end

   initial
   begin
      {rstn, nvmLoad, measValid, cycleTick, minuteTick} = 5'b00000;
      {measVoltage, measTemp, chargeLevel, hv, lv, ht, lt, lc, tag} = '0;
      void'($urandom(64336));
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      foreach (RC[i]) rd(RC[i], RV[i]);
      $display("test reset values done");
      foreach (TC[i])
      begin
         d = TL[i] + 16'($urandom % TS[i]);
         host.issue(1'b1, TC[i], d);
         rd(TC[i], d);
         host.issue(1'b1, TC[i], 16'h0000);
      end
      bad(1'b0, 8'h00);
      bad(1'b1, CMD_CYCLE_COUNT);
      bad(1'b1, CMD_VERSION);
      bad(1'b0, 8'h12);
      rd(CMD_VERSION, 16'h5A01);
      rd(CMD_CHECKSUM_LO, 16'hABCD);
      rd(CMD_CHECKSUM_HI, 16'h1234);
      host.idle();
      $display("test access done");
      v = VOLT_MIN + 16'($urandom % 16'h09C5);
      d = TEMP_MIN + 16'($urandom % 16'h044D);
      sample(v, d, 16'h0050, 5'b00000);
      sample(VOLT_MIN, TEMP_MAX, 16'h0050, 5'b00000);
      rd(CMD_PEAK_VOLT, v);
      rd(CMD_FLOOR_VOLT, VOLT_MIN);
      rd(CMD_PEAK_TEMP, TEMP_MAX);
      rd(CMD_FLOOR_TEMP, d);
      rd(CMD_ALARM_STATE, ALARM_STATE_RESET);
      host.issue(1'b1, CMD_HIGH_VOLT_THR, 16'h1000);
      host.issue(1'b1, CMD_LOW_CHARGE_THR, 16'h0032);
      host.idle();
      sample(16'h1000, 16'h0AAC, 16'h0032, 5'b10001);
      rd(CMD_ALARM_STATE, ALARM_STATE_RESET | 16'h8200);
      host.idle();
      $display("test logs and alarms done");
      tick(1'b0, 3);
      tick(1'b1, 2);
      rd(CMD_CYCLE_COUNT, 16'h0003);
      rd(CMD_RUNTIME_LO, 16'h0002);
      rd(CMD_RUNTIME_HI, 16'h0000);
      rd(CMD_TEMP_ACC_LO, (16'h0AAC >> 4) * 16'h0002);
      rd(CMD_CHARGE_ACC_LO, 16'h0064);
      rd(CMD_CHARGE_ACC_HI, 16'h0000);
      host.issue(1'b1, CMD_RUNTIME_HI, 16'hFFFF);
      rd(CMD_RUNTIME_HI, RUNTIME_HI_MASK);
      host.issue(1'b1, CMD_ALARM_STATE, 16'h0000);
      rd(CMD_ALARM_STATE, 16'h0000);
      host.issue(1'b1, CMD_PEAK_VOLT, 16'h0ABC);
      rd(CMD_PEAK_VOLT, 16'h0ABC);
      host.idle();
      $display("test counters done");
      {hv, lv, ht, lt, lc} <= {16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom),
         16'($urandom)};
      tag <= $urandom;
      @(posedge clock);
      nvmLoad <= 1'b1;
      rd(CMD_HIGH_VOLT_THR, hv);
      nvmLoad <= 1'b0;
      rd(CMD_LOW_VOLT_THR, lv);
      rd(CMD_HIGH_TEMP_THR, ht);
      rd(CMD_LOW_TEMP_THR, lt);
      rd(CMD_LOW_CHARGE_THR, lc);
      rd(CMD_OWNER_LO, tag[15:0]);
      rd(CMD_OWNER_HI, tag[31:16]);
      host.idle();
      $display("test load done");
      for (int k = 0; k < 20 && expQ.size() > 0; k++) @(posedge clock);
      if (expQ.size() > 0 || flagQ.size() > 0)
         fail("answers missing");
      end_of_test();
   end
endmodule : testbench
`default_nettype wire

// ==== hw/glar_pkg.sv ====
package glar_pkg;
   // =========================================
   // Command codes of the register set
   localparam logic [7:0] CMD_VERSION = 8'h11;
   localparam logic [7:0] CMD_LOW_CHARGE_THR = 8'h13;
   localparam logic [7:0] CMD_LOW_VOLT_THR = 8'h14;
   localparam logic [7:0] CMD_CYCLE_COUNT = 8'h17;
   localparam logic [7:0] CMD_ALARM_STATE = 8'h19;
   localparam logic [7:0] CMD_HIGH_VOLT_THR = 8'h1F;
   localparam logic [7:0] CMD_LOW_TEMP_THR = 8'h20;
   localparam logic [7:0] CMD_HIGH_TEMP_THR = 8'h21;
   localparam logic [7:0] CMD_RUNTIME_LO = 8'h24;
   localparam logic [7:0] CMD_RUNTIME_HI = 8'h25;
   localparam logic [7:0] CMD_TEMP_ACC_LO = 8'h26;
   localparam logic [7:0] CMD_TEMP_ACC_HI = 8'h27;
   localparam logic [7:0] CMD_CHARGE_ACC_LO = 8'h28;
   localparam logic [7:0] CMD_CHARGE_ACC_HI = 8'h29;
   localparam logic [7:0] CMD_PEAK_VOLT = 8'h2A;
   localparam logic [7:0] CMD_FLOOR_VOLT = 8'h2B;
   localparam logic [7:0] CMD_PEAK_TEMP = 8'h2C;
   localparam logic [7:0] CMD_FLOOR_TEMP = 8'h2D;
   localparam logic [7:0] CMD_OWNER_LO = 8'h36;
   localparam logic [7:0] CMD_OWNER_HI = 8'h37;
   localparam logic [7:0] CMD_CHECKSUM_LO = 8'h38;
   localparam logic [7:0] CMD_CHECKSUM_HI = 8'h39;
   // =========================================
   // Reset values and ranges
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam logic [15:0] PEAK_VOLT_RESET = 16'h0000;
   localparam logic [15:0] FLOOR_VOLT_RESET = 16'h1388;
   localparam logic [15:0] PEAK_TEMP_RESET = 16'h0980;
   localparam logic [15:0] FLOOR_TEMP_RESET = 16'h0DCC;
   localparam logic [15:0] ALARM_STATE_RESET = 16'h00C0;
   localparam logic [15:0] VOLT_MIN = 16'h09C4;
   localparam logic [15:0] VOLT_MAX = 16'h1388;
   localparam logic [15:0] TEMP_MIN = 16'h0980;
   localparam logic [15:0] TEMP_MAX = 16'h0DCC;
   localparam logic [15:0] CHARGE_MAX = 16'h0064;
   localparam logic [15:0] RUNTIME_HI_MASK = 16'h00FF;
   // =========================================
   // Alarm bit positions in the alarm state word
   localparam int BIT_HIGH_VOLT = 15;
   localparam int BIT_HIGH_TEMP = 12;
   localparam int BIT_LOW_TEMP = 11;
   localparam int BIT_LOW_VOLT = 10;
   localparam int BIT_LOW_CHARGE = 9;
   // =========================================
   // Command port states
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_WRITE = 3'b100
   } glar_state_t;
endpackage : glar_pkg

// ==== hw/glar_registers.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Peak voltage log starts at zero; each higher measured voltage replaces it.
// - Floor voltage log starts at 5 V; each lower measured voltage replaces it.
// - Peak temperature log starts at -30 C code; higher readings replace it.
// - Floor temperature log starts at +80 C code; lower readings replace it.
// - Alarm state word reports alarms only, not battery state; resets to 0x00C0.
// - High voltage threshold zero disables; otherwise millivolt threshold.
// - Low voltage threshold zero disables; otherwise millivolt threshold.
// - High temperature threshold zero disables; otherwise 0.1 K code threshold.
// - Low temperature threshold zero disables; otherwise 0.1 K code threshold.
// - Low charge threshold zero disables; one to one hundred is percent.
// - Thresholds and owner tag load their initial values from non-volatile memory.
module glar_registers
   import glar_pkg::*;
#(
   parameter logic [15:0] VERSION_CODE = 16'h0001,
   parameter logic [31:0] CHECKSUM_VALUE = 32'h00000000
)
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic cmdValid,
   input wire logic cmdWrite,
   input wire logic [7:0] cmdCode,
   input wire logic [15:0] cmdWdata,
   output logic [15:0] cmdRdata,
   output logic cmdRvalid,
   output logic cmdError,
   input wire logic nvmLoad,
   input wire logic [15:0] nvmHighVolt,
   input wire logic [15:0] nvmLowVolt,
   input wire logic [15:0] nvmHighTemp,
   input wire logic [15:0] nvmLowTemp,
   input wire logic [15:0] nvmLowCharge,
   input wire logic [31:0] nvmOwnerTag,
   input wire logic measValid,
   input wire logic [15:0] measVoltage,
   input wire logic [15:0] measTemp,
   input wire logic [15:0] relativeChargeLevel,
   input wire logic [15:0] batteryStateBits,
   input wire logic cycleTick,
   input wire logic minuteTick,
   output logic [4:0] alarmFlags
);
   // =========================================
   // Reset release
   logic rstMeta_q;
   logic rstSync_q;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end
      else
      begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end
   wire logic rstnInt = rstSync_q;

   // =========================================
   // Registers
   logic [15:0] cycleCount_q;
   logic [15:0] alarmState_q;
   logic [15:0] highVoltThr_q;
   logic [15:0] lowVoltThr_q;
   logic [15:0] highTempThr_q;
   logic [15:0] lowTempThr_q;
   logic [15:0] lowChargeThr_q;
   logic [31:0] runtime_q;
   logic [31:0] tempAcc_q;
   logic [31:0] chargeAcc_q;
   logic [15:0] peakVolt_q;
   logic [15:0] floorVolt_q;
   logic [15:0] peakTemp_q;
   logic [15:0] floorTemp_q;
   logic [31:0] ownerTag_q;
   glar_state_t state_q;
   glar_state_t state_d;

   function automatic logic wr(input logic [7:0] code, input logic [7:0] want,
                               input logic en, input logic w);
      wr = en && w && (code == want);
   endfunction : wr

   // =========================================
   // Command decode
   wire logic known = (cmdCode == CMD_VERSION) || (cmdCode == CMD_LOW_CHARGE_THR)
      || (cmdCode == CMD_LOW_VOLT_THR) || (cmdCode == CMD_CYCLE_COUNT)
      || (cmdCode == CMD_ALARM_STATE) || (cmdCode == CMD_HIGH_VOLT_THR)
      || (cmdCode == CMD_LOW_TEMP_THR) || (cmdCode == CMD_HIGH_TEMP_THR)
      || ((cmdCode >= CMD_RUNTIME_LO) && (cmdCode <= CMD_FLOOR_TEMP))
      || ((cmdCode >= CMD_OWNER_LO) && (cmdCode <= CMD_CHECKSUM_HI));
   wire logic readOnly = (cmdCode == CMD_VERSION) || (cmdCode == CMD_CYCLE_COUNT)
      || ((cmdCode >= CMD_OWNER_LO) && (cmdCode <= CMD_CHECKSUM_HI));
   wire logic accept = cmdValid && known && !(cmdWrite && readOnly);
   wire logic wen = accept && cmdWrite;
   wire logic prohibited = cmdValid && !accept;

   logic [15:0] readMux;
   always_comb
   begin
      unique case (cmdCode)
         CMD_VERSION: readMux = VERSION_CODE;
         CMD_LOW_CHARGE_THR: readMux = lowChargeThr_q;
         CMD_LOW_VOLT_THR: readMux = lowVoltThr_q;
         CMD_CYCLE_COUNT: readMux = cycleCount_q;
         CMD_ALARM_STATE: readMux = alarmState_q;
         CMD_HIGH_VOLT_THR: readMux = highVoltThr_q;
         CMD_LOW_TEMP_THR: readMux = lowTempThr_q;
         CMD_HIGH_TEMP_THR: readMux = highTempThr_q;
         CMD_RUNTIME_LO: readMux = runtime_q[15:0];
         CMD_RUNTIME_HI: readMux = runtime_q[31:16];
         CMD_TEMP_ACC_LO: readMux = tempAcc_q[15:0];
         CMD_TEMP_ACC_HI: readMux = tempAcc_q[31:16];
         CMD_CHARGE_ACC_LO: readMux = chargeAcc_q[15:0];
         CMD_CHARGE_ACC_HI: readMux = chargeAcc_q[31:16];
         CMD_PEAK_VOLT: readMux = peakVolt_q;
         CMD_FLOOR_VOLT: readMux = floorVolt_q;
         CMD_PEAK_TEMP: readMux = peakTemp_q;
         CMD_FLOOR_TEMP: readMux = floorTemp_q;
         CMD_OWNER_LO: readMux = ownerTag_q[15:0];
         CMD_OWNER_HI: readMux = ownerTag_q[31:16];
         CMD_CHECKSUM_LO: readMux = CHECKSUM_VALUE[15:0];
         CMD_CHECKSUM_HI: readMux = CHECKSUM_VALUE[31:16];
         default: readMux = ZERO_WORD;
      endcase
   end

   // =========================================
   // Command port state: answers come one cycle after the request.
   always_comb
   begin
      state_d = ST_IDLE;
      if (accept)
      begin
         state_d = cmdWrite ? ST_WRITE : ST_READ;
      end
   end

   always_ff @(posedge clock or negedge rstnInt)
   begin
      if (!rstnInt)
      begin
         state_q <= ST_IDLE;
         cmdRdata <= ZERO_WORD;
         cmdRvalid <= 1'b0;
         cmdError <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cmdRvalid <= accept && !cmdWrite;
         cmdRdata <= (accept && !cmdWrite) ? readMux : ZERO_WORD;
         cmdError <= prohibited;
      end
   end

   // =========================================
   // Alarm comparators
   wire logic hitHighVolt;
   wire logic hitLowVolt;
   wire logic hitHighTemp;
   wire logic hitLowTemp;
   wire logic hitLowCharge;
   glar_threshold_check #(.ABOVE(1'b1)) uHighVolt
   (
      .threshold(highVoltThr_q),
      .measured(measVoltage),
      .sampleValid(measValid),
      .alarmHit(hitHighVolt)
   );
   glar_threshold_check #(.ABOVE(1'b0)) uLowVolt
   (
      .threshold(lowVoltThr_q),
      .measured(measVoltage),
      .sampleValid(measValid),
      .alarmHit(hitLowVolt)
   );
   glar_threshold_check #(.ABOVE(1'b1)) uHighTemp
   (
      .threshold(highTempThr_q),
      .measured(measTemp),
      .sampleValid(measValid),
      .alarmHit(hitHighTemp)
   );
   glar_threshold_check #(.ABOVE(1'b0)) uLowTemp
   (
      .threshold(lowTempThr_q),
      .measured(measTemp),
      .sampleValid(measValid),
      .alarmHit(hitLowTemp)
   );
   glar_threshold_check #(.ABOVE(1'b0)) uLowCharge
   (
      .threshold(lowChargeThr_q),
      .measured(relativeChargeLevel),
      .sampleValid(measValid),
      .alarmHit(hitLowCharge)
   );

   // Host writes replace the word; new alarm events win over that write.
   logic [15:0] alarmSet;
   always_comb
   begin
      alarmSet = ZERO_WORD;
      alarmSet[BIT_HIGH_VOLT] = hitHighVolt;
      alarmSet[BIT_HIGH_TEMP] = hitHighTemp;
      alarmSet[BIT_LOW_TEMP] = hitLowTemp;
      alarmSet[BIT_LOW_VOLT] = hitLowVolt;
      alarmSet[BIT_LOW_CHARGE] = hitLowCharge;
   end
   wire logic [15:0] alarmBase = wr(cmdCode, CMD_ALARM_STATE, wen, 1'b1) ? cmdWdata
      : alarmState_q;

   always_ff @(posedge clock or negedge rstnInt)
   begin
      if (!rstnInt)
      begin
         alarmState_q <= ALARM_STATE_RESET;
         alarmFlags <= 5'b00000;
      end
      else
      begin
         alarmState_q <= alarmBase | alarmSet;
         alarmFlags <= {hitHighVolt, hitHighTemp, hitLowTemp, hitLowVolt, hitLowCharge};
      end
   end

   // =========================================
   // Thresholds and owner tag
   always_ff @(posedge clock or negedge rstnInt)
   begin
      if (!rstnInt)
      begin
         highVoltThr_q <= ZERO_WORD;
         lowVoltThr_q <= ZERO_WORD;
         highTempThr_q <= ZERO_WORD;
         lowTempThr_q <= ZERO_WORD;
         lowChargeThr_q <= ZERO_WORD;
         ownerTag_q <= 32'h00000000;
      end
      else if (nvmLoad)
      begin
         highVoltThr_q <= nvmHighVolt;
         lowVoltThr_q <= nvmLowVolt;
         highTempThr_q <= nvmHighTemp;
         lowTempThr_q <= nvmLowTemp;
         lowChargeThr_q <= nvmLowCharge;
         ownerTag_q <= nvmOwnerTag;
      end
      else
      begin
         if (wr(cmdCode, CMD_HIGH_VOLT_THR, wen, 1'b1))
            highVoltThr_q <= cmdWdata;
         if (wr(cmdCode, CMD_LOW_VOLT_THR, wen, 1'b1))
            lowVoltThr_q <= cmdWdata;
         if (wr(cmdCode, CMD_HIGH_TEMP_THR, wen, 1'b1))
            highTempThr_q <= cmdWdata;
         if (wr(cmdCode, CMD_LOW_TEMP_THR, wen, 1'b1))
            lowTempThr_q <= cmdWdata;
         if (wr(cmdCode, CMD_LOW_CHARGE_THR, wen, 1'b1))
            lowChargeThr_q <= cmdWdata;
      end
   end

   // =========================================
   // Lifetime counters; host writes win over a tick in the same cycle.
   always_ff @(posedge clock or negedge rstnInt)
   begin
      if (!rstnInt)
      begin
         cycleCount_q <= ZERO_WORD;
         runtime_q <= 32'h00000000;
         tempAcc_q <= 32'h00000000;
         chargeAcc_q <= 32'h00000000;
      end
      else
      begin
         if (cycleTick)
            cycleCount_q <= cycleCount_q + 16'h0001;
         if (wr(cmdCode, CMD_RUNTIME_LO, wen, 1'b1))
            runtime_q[15:0] <= cmdWdata;
         else if (wr(cmdCode, CMD_RUNTIME_HI, wen, 1'b1))
            runtime_q[31:16] <= cmdWdata & RUNTIME_HI_MASK;
         else if (minuteTick && (runtime_q != 32'h00FFFFFF))
            runtime_q <= runtime_q + 32'h00000001;
         if (wr(cmdCode, CMD_TEMP_ACC_LO, wen, 1'b1))
            tempAcc_q[15:0] <= cmdWdata;
         else if (wr(cmdCode, CMD_TEMP_ACC_HI, wen, 1'b1))
            tempAcc_q[31:16] <= cmdWdata;
         else if (minuteTick)
            tempAcc_q <= tempAcc_q + {20'h00000, measTemp[15:4]};
         if (wr(cmdCode, CMD_CHARGE_ACC_LO, wen, 1'b1))
            chargeAcc_q[15:0] <= cmdWdata;
         else if (wr(cmdCode, CMD_CHARGE_ACC_HI, wen, 1'b1))
            chargeAcc_q[31:16] <= cmdWdata;
         else if (minuteTick)
            chargeAcc_q <= chargeAcc_q + {16'h0000, relativeChargeLevel};
      end
   end

   // =========================================
   // Historical extremes; a host write takes priority over a sample.
   always_ff @(posedge clock or negedge rstnInt)
   begin
      if (!rstnInt)
      begin
         peakVolt_q <= PEAK_VOLT_RESET;
         floorVolt_q <= FLOOR_VOLT_RESET;
         peakTemp_q <= PEAK_TEMP_RESET;
         floorTemp_q <= FLOOR_TEMP_RESET;
      end
      else
      begin
         if (wr(cmdCode, CMD_PEAK_VOLT, wen, 1'b1))
            peakVolt_q <= cmdWdata;
         else if (measValid && (measVoltage > peakVolt_q))
            peakVolt_q <= measVoltage;
         if (wr(cmdCode, CMD_FLOOR_VOLT, wen, 1'b1))
            floorVolt_q <= cmdWdata;
         else if (measValid && (measVoltage < floorVolt_q))
            floorVolt_q <= measVoltage;
         if (wr(cmdCode, CMD_PEAK_TEMP, wen, 1'b1))
            peakTemp_q <= cmdWdata;
         else if (measValid && (measTemp > peakTemp_q))
            peakTemp_q <= measTemp;
         if (wr(cmdCode, CMD_FLOOR_TEMP, wen, 1'b1))
            floorTemp_q <= cmdWdata;
         else if (measValid && (measTemp < floorTemp_q))
            floorTemp_q <= measTemp;
      end
   end
endmodule : glar_registers
`default_nettype wire

// ==== hw/glar_threshold_check.sv ====
`timescale 1ns/1ps
`default_nettype none
// =========================================
// One alarm comparator: zero threshold disables it.
module glar_threshold_check
#(
   parameter bit ABOVE = 1'b1
)
(
   input wire logic [15:0] threshold,
   input wire logic [15:0] measured,
   input wire logic sampleValid,
   output logic alarmHit
);
   wire logic enabled = (threshold != 16'h0000);
   wire logic crossed = ABOVE ? (measured >= threshold) : (measured <= threshold);
   assign alarmHit = sampleValid && enabled && crossed;
endmodule : glar_threshold_check
`default_nettype wire
